/* File: design/sdm_map.svh */
// register map and field positions of the sdram mode-field block
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef SDM_MAP_SVH
`define SDM_MAP_SVH
// word index = byte address bits [3:2]
`define SDM_IDX_CTRL   2'h0
`define SDM_IDX_STAT   2'h1
// control field positions
`define SDM_COLW_LSB   16
`define SDM_SHIFT_BIT  12
`define SDM_RFEN_BIT   11
`define SDM_RTYPE_BIT  10
`define SDM_OBANK_BIT  8
// writable bits; all else reads zero
`define SDM_CTRL_WMASK 32'h0003_1d00
`define SDM_CTRL_RST   32'h0000_0000
// column width base and prohibited code
`define SDM_COLW_BASE  5'h08
`define SDM_COLW_BAD   2'h3
// axi responses
`define SDM_RESP_OKAY  2'h0
`define SDM_RESP_SLV   2'h2
`endif

/* File: design/sdm_pkg.sv */
// types shared by the sdram mode-field block
// assumes sdm_map.svh holds every number
package sdm_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RW, ST_SELF} sdm_state_t;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR,
    CMD_PRE, CMD_REF, CMD_SELF_ENT, CMD_SELF_EXIT
  } sdm_cmd_t;
endpackage

/* File: design/sdm_ctrl.sv */
// sdram controller mode fields: control register,
// address split, refresh and access command sequencing
// assumes same-clock requester and refresh timer tick;
// pad ring applies the half-cycle launch/capture shift
`timescale 1ns/1ps
`default_nettype none
`include "sdm_map.svh"

// Overview of operation
// - column code picks 8, 9, 10 bits
// - reserved bits read zero, writes ignored
// - shift clear: launch and capture rising edge
// - shift set: launch and capture falling edge
// - no refresh at all unless enabled
// - self-refresh entered when selected, after any open row is precharged
// - auto-refresh paced by refresh timer ticks
// - open-bank bit chooses the access style
// - zero auto-precharge, one keeps row open
module sdm_ctrl #(
  parameter int ADDR_W = 24,
  parameter int ROW_W  = 13
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [3:0]        awaddr,
  input  wire logic              awvalid,
  output var  logic              awready_ff,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready_ff,
  output var  logic [1:0]        bresp_ff,
  output var  logic              bvalid_ff,
  input  wire logic              bready,
  input  wire logic [3:0]        araddr,
  input  wire logic              arvalid,
  output var  logic              arready_ff,
  output var  logic [31:0]       rdata_ff,
  output var  logic [1:0]        rresp_ff,
  output var  logic              rvalid_ff,
  input  wire logic              rready,
  input  wire logic              acc_req,
  input  wire logic              acc_we,
  input  wire logic [ADDR_W-1:0] acc_addr,
  output var  logic              acc_ack_ff,
  input  wire logic              refresh_tick,
  output var  sdm_pkg::sdm_cmd_t sd_cmd_ff,
  output var  logic [1:0]        sd_bank_ff,
  output var  logic [ROW_W-1:0]  sd_row_ff,
  output var  logic [9:0]        sd_col_ff,
  output var  logic              sd_ap_ff,
  output var  logic              launch_fall_ff,
  output var  logic              capture_fall_ff
);

  // ==========================================
  // address split
  // returns {row, bank, col}; col is masked to its width
  function automatic logic [ROW_W+11:0] split(
    input logic [ADDR_W-1:0] a,
    input logic [1:0]        code);
    logic [4:0]        w;
    logic [ADDR_W-1:0] hi;
    logic [9:0]        col;
    w   = `SDM_COLW_BASE + {3'h0, code};
    hi  = a >> w;
    col = 10'(a) & 10'((11'h1 << w) - 11'h1);
    split = {ROW_W'(hi >> 2), hi[1:0], col};
  endfunction

  // ==========================================
  // register bus state
  logic [31:0] ctrl_ff,    nxt_ctrl;
  logic [1:0]  awidx_ff,   nxt_awidx;
  logic [31:0] wdat_ff,    nxt_wdat;
  logic [3:0]  wstb_ff,    nxt_wstb;
  logic        nxt_awready, nxt_wready, nxt_bvalid;
  logic        nxt_arready, nxt_rvalid;
  logic [1:0]  nxt_bresp,  nxt_rresp;
  logic [31:0] nxt_rdata,  stat, wmerge;
  integer      i;

  // ==========================================
  // sequencer state
  sdm_pkg::sdm_state_t st_ff, nxt_st;
  sdm_pkg::sdm_cmd_t   nxt_cmd;
  logic              open_ff,  nxt_open;
  logic [1:0]        obank_ff, nxt_obank;
  logic [ROW_W-1:0]  orow_ff,  nxt_orow;
  logic              pend_ff,  nxt_pend;
  logic [1:0]        nxt_bank;
  logic [ROW_W-1:0]  nxt_row;
  logic [9:0]        nxt_col;
  logic              nxt_ap, nxt_ack;
  logic [ROW_W+11:0] sp;
  logic              rfen, rtype, obsel;
  logic [1:0]        colw;

  assign rfen  = ctrl_ff[`SDM_RFEN_BIT];
  assign rtype = ctrl_ff[`SDM_RTYPE_BIT];
  assign obsel = ctrl_ff[`SDM_OBANK_BIT];
  assign colw  = ctrl_ff[`SDM_COLW_LSB+1:`SDM_COLW_LSB];
  assign sp    = split(acc_addr, colw);

  // status view of the sequencer
  assign stat = {26'h0, pend_ff, open_ff,
                 (st_ff == sdm_pkg::ST_SELF),
                 (colw == `SDM_COLW_BAD), obsel, rfen};

  // ==========================================
  // axi4-lite write and read channels
  // address and data are taken in either order; the
  // write lands once both are held, on the same edge that bvalid rises
  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_awidx   = awidx_ff;
    nxt_wdat    = wdat_ff;
    nxt_wstb    = wstb_ff;
    nxt_awready = awready_ff;
    nxt_wready  = wready_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_arready = arready_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    wmerge      = ctrl_ff;
    for (i = 0; i < 4; i++) begin
      if (wstb_ff[i]) begin
        wmerge[i*8 +: 8] = wdat_ff[i*8 +: 8];
      end
    end
    if (awvalid && awready_ff) begin
      nxt_awidx   = awaddr[3:2];
      nxt_awready = 1'b0;
    end
    if (wvalid && wready_ff) begin
      nxt_wdat   = wdata;
      nxt_wstb   = wstrb;
      nxt_wready = 1'b0;
    end
    if (!awready_ff && !wready_ff && !bvalid_ff) begin
      nxt_bvalid = 1'b1;
      if (awidx_ff == `SDM_IDX_CTRL) begin
        // reserved positions never stored
        nxt_ctrl  = wmerge & `SDM_CTRL_WMASK;
        nxt_bresp = `SDM_RESP_OKAY;
      end else begin
        // status is read-only; other words unmapped
        nxt_bresp = `SDM_RESP_SLV;
      end
    end
    if (bvalid_ff && bready) begin
      nxt_bvalid  = 1'b0;
      nxt_awready = 1'b1;
      nxt_wready  = 1'b1;
    end
    if (arvalid && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid  = 1'b1;
      nxt_rresp   = `SDM_RESP_OKAY;
      unique case (araddr[3:2])
        `SDM_IDX_CTRL: nxt_rdata = ctrl_ff & `SDM_CTRL_WMASK;
        `SDM_IDX_STAT: nxt_rdata = stat;
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = `SDM_RESP_SLV;
        end
      endcase
    end
    if (rvalid_ff && rready) begin
      nxt_rvalid  = 1'b0;
      nxt_arready = 1'b1;
    end
  end

  // ==========================================
  // command sequencer
  // refresh wins over accesses; no inter-command gaps are
  // timed here, the command timing fields own that
  always_comb begin
    nxt_st    = st_ff;
    nxt_cmd   = sdm_pkg::CMD_NOP;
    nxt_open  = open_ff;
    nxt_obank = obank_ff;
    nxt_orow  = orow_ff;
    nxt_bank  = sd_bank_ff;
    nxt_row   = sd_row_ff;
    nxt_col   = sd_col_ff;
    nxt_ap    = 1'b0;
    nxt_ack   = 1'b0;
    // tick sets, issue clears, set wins over a refresh issue; off and self-refresh drop all
    nxt_pend  = rfen && (refresh_tick || pend_ff);
    unique case (st_ff)
      sdm_pkg::ST_IDLE: begin
        if (rfen && (rtype || pend_ff) && open_ff) begin
          // close the row before any refresh
          nxt_cmd  = sdm_pkg::CMD_PRE;
          nxt_ap   = 1'b1;                        // all banks
          nxt_open = 1'b0;
        end else if (rfen && rtype) begin
          nxt_cmd  = sdm_pkg::CMD_SELF_ENT;
          nxt_st   = sdm_pkg::ST_SELF;
          nxt_pend = 1'b0;
        end else if (rfen && pend_ff) begin
          nxt_cmd  = sdm_pkg::CMD_REF;
          nxt_pend = refresh_tick;
        end else if (acc_req && !acc_ack_ff) begin
          nxt_bank = sp[11:10];
          nxt_row  = sp[ROW_W+11:12];
          nxt_col  = sp[9:0];
          if (open_ff && obank_ff == sp[11:10] &&
              orow_ff == sp[ROW_W+11:12]) begin
            // row hit in bank-active mode
            nxt_st = sdm_pkg::ST_RW;
          end else if (open_ff) begin
            nxt_cmd  = sdm_pkg::CMD_PRE;
            nxt_ap   = 1'b1;
            nxt_open = 1'b0;
          end else begin
            nxt_cmd = sdm_pkg::CMD_ACT;
            nxt_st  = sdm_pkg::ST_RW;
          end
        end
      end
      sdm_pkg::ST_RW: begin
        nxt_cmd = acc_we ? sdm_pkg::CMD_WR : sdm_pkg::CMD_RD;
        nxt_ap  = !obsel;
        nxt_ack = 1'b1;
        // bank-active leaves the row open for a later hit
        nxt_open  = obsel;
        nxt_obank = sd_bank_ff;
        nxt_orow  = sd_row_ff;
        nxt_st    = sdm_pkg::ST_IDLE;
      end
      sdm_pkg::ST_SELF: begin
        nxt_pend = 1'b0;
        if (!(rfen && rtype)) begin
          nxt_cmd = sdm_pkg::CMD_SELF_EXIT;
          nxt_st  = sdm_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st = sdm_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================
  // registers; ce low freezes every flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff         <= `SDM_CTRL_RST;
      awidx_ff        <= 2'h0;
      wdat_ff         <= 32'h0;
      wstb_ff         <= 4'h0;
      awready_ff      <= 1'b1;
      wready_ff       <= 1'b1;
      bvalid_ff       <= 1'b0;
      bresp_ff        <= 2'h0;
      arready_ff      <= 1'b1;
      rvalid_ff       <= 1'b0;
      rdata_ff        <= 32'h0;
      rresp_ff        <= 2'h0;
      st_ff           <= sdm_pkg::ST_IDLE;
      sd_cmd_ff       <= sdm_pkg::CMD_NOP;
      open_ff         <= 1'b0;
      obank_ff        <= 2'h0;
      orow_ff         <= '0;
      pend_ff         <= 1'b0;
      sd_bank_ff      <= 2'h0;
      sd_row_ff       <= '0;
      sd_col_ff       <= 10'h0;
      sd_ap_ff        <= 1'b0;
      acc_ack_ff      <= 1'b0;
      launch_fall_ff  <= 1'b0;
      capture_fall_ff <= 1'b0;
    end else if (ce) begin
      ctrl_ff         <= nxt_ctrl;
      awidx_ff        <= nxt_awidx;
      wdat_ff         <= nxt_wdat;
      wstb_ff         <= nxt_wstb;
      awready_ff      <= nxt_awready;
      wready_ff       <= nxt_wready;
      bvalid_ff       <= nxt_bvalid;
      bresp_ff        <= nxt_bresp;
      arready_ff      <= nxt_arready;
      rvalid_ff       <= nxt_rvalid;
      rdata_ff        <= nxt_rdata;
      rresp_ff        <= nxt_rresp;
      st_ff           <= nxt_st;
      sd_cmd_ff       <= nxt_cmd;
      open_ff         <= nxt_open;
      obank_ff        <= nxt_obank;
      orow_ff         <= nxt_orow;
      pend_ff         <= nxt_pend;
      sd_bank_ff      <= nxt_bank;
      sd_row_ff       <= nxt_row;
      sd_col_ff       <= nxt_col;
      sd_ap_ff        <= nxt_ap;
      acc_ack_ff      <= nxt_ack;
      // pad ring retimes launch/capture by half a cycle
      launch_fall_ff  <= nxt_ctrl[`SDM_SHIFT_BIT];
      capture_fall_ff <= nxt_ctrl[`SDM_SHIFT_BIT];
    end
  end

endmodule
`default_nettype wire

/* File: verif/sdm_ctrl_properties.sv */
// checker: bus answers and command order of sdm_ctrl
// assumes it sits on the sdm_ctrl ports through the bind below
`timescale 1ns/1ps
`default_nettype none
module sdm_chk (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              awvalid,
  input wire logic              awready_ff,
  input wire logic              wvalid,
  input wire logic              wready_ff,
  input wire logic              arvalid,
  input wire logic              arready_ff,
  input wire logic              rvalid_ff,
  input wire logic              rready,
  input wire logic [31:0]       rdata_ff,
  input wire logic              bvalid_ff,
  input wire logic              acc_ack_ff,
  input wire sdm_pkg::sdm_cmd_t sd_cmd_ff,
  input wire logic              launch_fall_ff,
  input wire logic              capture_fall_ff
);
  // ========
  // properties, one clock domain
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wtake;
    awvalid && awready_ff && wvalid && wready_ff;
  endsequence
  sequence s_act;
    sd_cmd_ff == sdm_pkg::CMD_ACT;
  endsequence
  a_write_resp: assert property (s_wtake |=> ##1 bvalid_ff) else $error("write not answered");
  a_read_resp: assert property (arvalid && arready_ff |=> rvalid_ff) else $error("read not answered");
  a_rdata_hold: assert property (rvalid_ff && !rready |=> rvalid_ff && $stable(rdata_ff)) else $error("read dropped");
  a_reserved_zero: assert property (rvalid_ff |-> rdata_ff[15:13] == 3'h0 && !rdata_ff[9]) else $error("reserved set");
  a_edge_pair: assert property (launch_fall_ff == capture_fall_ff) else $error("launch and capture differ");
  // the edge choice may only move when a control write lands, never on its own
  a_edge_on_write: assert property ($changed(launch_fall_ff) |-> bvalid_ff) else $error("edge moved unasked");
  a_ack_cmd: assert property (acc_ack_ff |-> sd_cmd_ff inside {sdm_pkg::CMD_RD, sdm_pkg::CMD_WR}) else $error("bad ack");
  a_act_access: assert property (s_act |=> acc_ack_ff) else $error("activate not followed");
  a_self_quiet: assert property (sd_cmd_ff == sdm_pkg::CMD_SELF_ENT |=> (sd_cmd_ff != sdm_pkg::CMD_ACT) [*2])
    else $error("activate in self-refresh");
endmodule
bind sdm_ctrl sdm_chk chk_u (.aclk, .aresetn, .awvalid, .awready_ff, .wvalid, .wready_ff, .arvalid, .arready_ff,
  .rvalid_ff, .rready, .rdata_ff, .bvalid_ff, .acc_ack_ff, .sd_cmd_ff, .launch_fall_ff, .capture_fall_ff);
`default_nettype wire

/* File: verif/sdm_sdram.sv */
// sdram chip model: tracks the open row, counts refreshes
// assumes commands last one cycle; no data pins exist here
`timescale 1ns/1ps
`default_nettype none
module sdm_sdram #(parameter int ROW_W = 13) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire sdm_pkg::sdm_cmd_t sd_cmd,
  input  wire logic [1:0]        sd_bank,
  input  wire logic [ROW_W-1:0]  sd_row,
  input  wire logic              sd_ap,
  output logic      [1:0]        act_bank,
  output logic      [ROW_W-1:0]  act_row,
  output logic      [7:0]        n_ref,
  output logic      [7:0]        n_self,
  output logic                   bad
);
  logic open_row;
  // ========
  // a real chip is unforgiving: access or refresh with the wrong row state is flagged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {open_row, bad, n_ref, n_self, act_bank, act_row} <= '0;
    end else begin
      case (sd_cmd)
        sdm_pkg::CMD_ACT: begin
          bad <= bad | open_row;
          open_row <= 1'b1;
          act_bank <= sd_bank;
          act_row <= sd_row;
        end
        sdm_pkg::CMD_RD, sdm_pkg::CMD_WR: begin
          bad <= bad | !open_row;
          open_row <= open_row & !sd_ap;
        end
        sdm_pkg::CMD_PRE: open_row <= 1'b0;
        sdm_pkg::CMD_REF: begin
          bad <= bad | open_row;
          n_ref <= n_ref + 8'h01;
        end
        sdm_pkg::CMD_SELF_ENT: begin
          bad <= bad | open_row;
          n_self <= n_self + 8'h01;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verif/sdram_ctrl_mode_fields_test.sv */
// testbench of sdm_ctrl: register bus, refresh and access split
// assumes sdm_sdram on the command side and 25 mhz aclk
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_mode_fields_test;
  logic              aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, acc_req, acc_we, refresh_tick;
  logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, acc_ack_ff, sd_ap_ff, bad;
  logic              launch_fall_ff, capture_fall_ff;
  logic [3:0]        awaddr, araddr, wstrb;
  logic [31:0]       wdata, rdata_ff, d;
  logic [1:0]        bresp_ff, rresp_ff, sd_bank_ff, act_bank, r;
  logic [23:0]       acc_addr, a;
  logic [12:0]       sd_row_ff, act_row;
  logic [9:0]        sd_col_ff;
  logic [7:0]        n_ref, n_self;
  sdm_pkg::sdm_cmd_t sd_cmd_ff;
  int                miscompares = 0, compares = 0, cyc = 0, c, ob;
  sdm_ctrl dut_u (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready_ff, .wdata, .wstrb, .wvalid, .wready_ff,
    .bresp_ff, .bvalid_ff, .bready, .araddr, .arvalid, .arready_ff, .rdata_ff, .rresp_ff, .rvalid_ff, .rready,
    .acc_req, .acc_we, .acc_addr, .acc_ack_ff, .refresh_tick, .sd_cmd_ff, .sd_bank_ff, .sd_row_ff, .sd_col_ff,
    .sd_ap_ff, .launch_fall_ff, .capture_fall_ff);
  sdm_sdram mem_u (.aclk, .aresetn, .sd_cmd(sd_cmd_ff), .sd_bank(sd_bank_ff), .sd_row(sd_row_ff),
    .sd_ap(sd_ap_ff), .act_bank, .act_row, .n_ref, .n_self, .bad);
  // ========
  // clock and hang guard; 20000 cycles is far beyond the run
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ========
  // tasks; bready and rready stay high, which keeps every answer taken at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready_ff) awvalid <= 1'b0;
      if (wready_ff) wvalid <= 1'b0;
    end while (bvalid_ff !== 1'b1);
    r = bresp_ff;
  endtask
  task automatic rd(input logic [3:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready_ff) arvalid <= 1'b0;
    end while (rvalid_ff !== 1'b1);
    d = rdata_ff;
    r = rresp_ff;
  endtask
  task automatic acc(input logic we, input logic [23:0] ad);
    @(posedge aclk);
    acc_we <= we;
    acc_addr <= ad;
    acc_req <= 1'b1;
    do @(posedge aclk); while (acc_ack_ff !== 1'b1);
    acc_req <= 1'b0;
  endtask
  task automatic tick_wait();
    refresh_tick <= 1'b1;
    @(posedge aclk);
    refresh_tick <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  // expected address field: w bits of ad starting at bit lsb
  function automatic logic [31:0] fld(input logic [23:0] ad, input int lsb, input int w);
    fld = 32'(ad >> lsb) & ((32'h1 << w) - 32'h1);
  endfunction
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ========
  // main sequence
  initial begin
    {ce, wstrb, bready, rready, aresetn} = {1'b1, 4'hf, 1'b1, 1'b1, 1'b0};
    {awvalid, wvalid, arvalid, acc_req, acc_we, refresh_tick, awaddr, araddr, wdata, acc_addr} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(32'h07868fed));
    wr(4'h0, 32'hffff_ffff);
    chk(32'(r), 32'h0);
    repeat (4) @(posedge aclk);
    chk(32'(n_self), 32'h1);
    chk(32'(launch_fall_ff), 32'h1);
    // status: self-refresh, code 11 flagged, open-bank and refresh bits mirrored
    rd(4'h4);
    chk(d, 32'h0000_000f);
    // status is read-only: the write is refused and the control word keeps its value
    wr(4'h4, 32'hffff_ffff);
    chk(32'(r), 32'h2);
    rd(4'h0);
    chk(d, 32'h0003_1d00);
    wr(4'h0, 32'h0);
    chk(32'(capture_fall_ff), 32'h0);
    rd(4'h8);
    chk(32'(r), 32'h2);
    chk(d, 32'h0);
    wr(4'hc, 32'h1);
    chk(32'(r), 32'h2);
    $display("test register fields done");
    tick_wait();
    chk(32'(n_ref), 32'h0);
    wr(4'h0, 32'h0000_0800);
    tick_wait();
    chk(32'(n_ref), 32'h1);
    // a tick that arrives while ce is low must be lost, not stored for later
    ce <= 1'b0;
    tick_wait();
    ce <= 1'b1;
    chk(32'(n_ref), 32'h1);
    wr(4'h0, 32'h0);
    $display("test refresh done");
    // first three passes hit each column code with all ones in every address bit that code maps
    for (int i = 0; i < 30; i++) begin
      c = (i < 3) ? i : $urandom % 3;
      ob = $urandom % 2;
      a = (i < 3) ? 24'hff_ffff : 24'($urandom);
      a = a & 24'((25'h1 << (23 + c)) - 1);
      // only area 2 holds sdram here, so either access style may be set
      wr(4'h0, 32'(c << 16) | 32'(ob << 8));
      acc(i[0], a);
      chk(32'(sd_cmd_ff), i[0] ? 32'h3 : 32'h2);
      chk(32'(sd_ap_ff), 32'(ob == 0));
      chk(32'(sd_col_ff), fld(a, 0, 8 + c));
      if (ob == 0) begin
        chk(32'(act_bank), fld(a, 8 + c, 2));
        chk(32'(act_row), fld(a, 10 + c, 13));
      end
    end
    chk(32'(bad), 32'h0);
    $display("test access split done");
    give_verdict();
  end
endmodule
`default_nettype wire
